// ===== verilog/dic_decoder.sv
`include "dic_consts.svh"
`default_nettype none
module dic_decoder (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // terminals
  input  wire dic_pkg::dic_term_s term_i,
  // command to motor control
  output dic_pkg::dic_cmd_s      cmd_o
);
  import dic_pkg::*;

  // ************************************************************
  // register bus
  // ************************************************************
  logic [31:0] ctrl_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic [31:0] fcount_reg;
  logic [31:0] ftime_reg;
  logic [31:0] life_reg;
  logic        run_reg;
  logic        rev_reg;
  logic        fast_reg;
  logic        armed_reg;
  logic        req;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // single wait state answer; ack drops the cycle after it is given
  assign req = cyc_i && stb_i && !ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `DIC_CTL_RESET;
    end else if (req && we_i && adr_i == `DIC_ADR_CTRL) begin
      ctrl_reg <= merge(ctrl_reg, dat_i, sel_i);
    end else begin
      // keypad start/stop are one-shot bits
      ctrl_reg[`DIC_CTL_KPD_START] <= 1'b0;
      ctrl_reg[`DIC_CTL_KPD_STOP]  <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_reg <= 32'h0000_0000;
    end else if (req && !we_i) begin
      unique case (adr_i)
        `DIC_ADR_CTRL:   rdat_reg <= ctrl_reg;
        `DIC_ADR_STATUS: rdat_reg <= {28'h0000000, armed_reg, fast_reg,
                                      rev_reg, run_reg};
        `DIC_ADR_FCOUNT: rdat_reg <= fcount_reg;
        `DIC_ADR_FTIME:  rdat_reg <= ftime_reg;
        `DIC_ADR_LIFE:   rdat_reg <= life_reg;
        default:         rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = rdat_reg;

  // ************************************************************
  // input sampling and edges
  // ************************************************************
  dic_term_s t_reg;
  dic_term_s tp_reg;
  dic_term_s rise;
  dic_term_s fall;

  // inputs are already synchronous; one stage keeps the previous sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t_reg  <= 5'h00;
      tp_reg <= 5'h00;
    end else begin
      t_reg  <= term_i;
      tp_reg <= t_reg;
    end
  end

  assign rise = t_reg & ~tp_reg;
  assign fall = ~t_reg & tp_reg;

  // ************************************************************
  // macro routing
  // ************************************************************
  logic [2:0] macro;
  dic_src_e   src;
  logic       kpd_auto;
  logic       pwr_auto;
  logic       lvl_run;
  logic       lvl_rev;
  logic       set_run;
  logic       set_rev;
  logic       do_stop;
  logic       do_fast;
  logic       latched;
  logic       enable;

  assign macro    = ctrl_reg[`DIC_CTL_MACRO_MSB:`DIC_CTL_MACRO_LSB];
  assign src      = dic_src_e'(ctrl_reg[`DIC_CTL_SRC_MSB:`DIC_CTL_SRC_LSB]);
  assign kpd_auto = ctrl_reg[`DIC_CTL_KPD_AUTO];
  assign pwr_auto = ctrl_reg[`DIC_CTL_PWR_AUTO];
  assign enable   = t_reg.di1;

  always_comb begin
    latched = 1'b1;
    lvl_run = 1'b0;
    lvl_rev = rev_reg;
    set_run = 1'b0;
    set_rev = rev_reg;
    do_stop = 1'b0;
    do_fast = 1'b0;
    unique case (macro)
      3'h0: begin
        lvl_run = t_reg.di1 && t_reg.di2;
        // di3 closed selects reverse, open selects forward
        lvl_rev = t_reg.di3;
      end
      3'h1: begin
        // di1 stop, di2 run forward, di3 run reverse
        lvl_run = t_reg.di1 && (t_reg.di2 ^ t_reg.di3);
        lvl_rev = t_reg.di3 ? 1'b1 : (t_reg.di2 ? 1'b0 : rev_reg);
      end
      3'h2: begin
        // di1 nc stop, di2 start fwd, di3 start rev
        latched = 1'b0;
        do_stop = fall.di1 || !t_reg.di1;
        set_run = t_reg.di1 && (rise.di2 || rise.di3);
        set_rev = rise.di3 ? 1'b1 : (rise.di2 ? 1'b0 : rev_reg);
        do_fast = fall.di4;
      end
      3'h3: begin
        // di1 nc stop; di2+di3 pressed together start, di2+di4 fast stop
        latched = 1'b0;
        do_stop = fall.di1 || !t_reg.di1;
        set_run = t_reg.di1 && t_reg.di2 && t_reg.di3 &&
                  (rise.di2 || rise.di3);
        do_fast = t_reg.di2 && t_reg.di4 &&
                  (rise.di2 || rise.di4);
      end
      default: begin
        // di1 latched run, di2 latched reverse select
        lvl_run = t_reg.di1;
        lvl_rev = t_reg.di2;
      end
    endcase
  end

  // ************************************************************
  // run state
  // ************************************************************
  logic pwr_done_reg;
  logic run_next;
  logic bus_run;
  logic sampled_reg;
  logic bus_prev_reg;

  // the first sample after reset is the reset value, not the contact
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sampled_reg <= 1'b0;
    end else begin
      sampled_reg <= 1'b1;
    end
  end

  // a run bit set before enable arrived stays ignored until cleared and set again
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_prev_reg <= 1'b0;
    end else begin
      bus_prev_reg <= ctrl_reg[`DIC_CTL_BUS_RUN];
    end
  end

  assign bus_run = ctrl_reg[`DIC_CTL_BUS_RUN] && !bus_prev_reg &&
                   enable;

  always_comb begin
    run_next = run_reg;
    unique case (src)
      DIC_SRC_KEYPAD: begin
        if (!enable || ctrl_reg[`DIC_CTL_KPD_STOP]) begin
          run_next = 1'b0;
        end else if (rise.di1 && kpd_auto) begin
          run_next = 1'b1;
        end else if (armed_reg && ctrl_reg[`DIC_CTL_KPD_START]) begin
          run_next = 1'b1;
        end
      end
      DIC_SRC_FIELDBUS: begin
        if (!enable || !ctrl_reg[`DIC_CTL_BUS_RUN]) begin
          run_next = 1'b0;
        end else if (bus_run) begin
          run_next = 1'b1;
        end
      end
      default: begin
        if (latched) begin
          run_next = lvl_run && (pwr_done_reg || !lvl_run || pwr_auto);
        end else if (do_stop || do_fast) begin
          run_next = 1'b0;
        end else if (set_run) begin
          run_next = 1'b1;
        end
      end
    endcase
  end

  // power-on: a run level already present waits for a fresh close
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_done_reg <= 1'b0;
    end else if ((sampled_reg && !lvl_run) || pwr_auto) begin
      pwr_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= (src == DIC_SRC_KEYPAD) && enable && !kpd_auto;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg  <= 1'b0;
      rev_reg  <= 1'b0;
      fast_reg <= 1'b0;
    end else begin
      run_reg  <= run_next;
      if (src == DIC_SRC_FIELDBUS) begin
        rev_reg <= ctrl_reg[`DIC_CTL_BUS_REV];
      end else if (src == DIC_SRC_TERMINAL) begin
        rev_reg <= latched ? lvl_rev : set_rev;
      end
      if (do_fast && src == DIC_SRC_TERMINAL) begin
        fast_reg <= 1'b1;
      end else if (run_next) begin
        fast_reg <= 1'b0;
      end
    end
  end

  assign cmd_o = '{run: run_reg, reverse_select: rev_reg,
                   fast_stop: fast_reg};

  // ************************************************************
  // fire mode and lifetime logs
  // ************************************************************
  logic [31:0] fsec_reg;
  logic [31:0] lsec_reg;
  logic [31:0] lhsec_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fcount_reg <= 32'h0000_0000;
    end else if (rise.fire_mode) begin
      fcount_reg <= fcount_reg + 32'h0000_0001;
    end
  end

  // fire time counted in seconds; a second is one clock-rate count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fsec_reg  <= 32'h0000_0000;
      ftime_reg <= 32'h0000_0000;
    end else if (t_reg.fire_mode) begin
      if (fsec_reg == `DIC_SEC_CYCLES - 32'h0000_0001) begin
        fsec_reg  <= 32'h0000_0000;
        ftime_reg <= ftime_reg + 32'h0000_0001;
      end else begin
        fsec_reg <= fsec_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lsec_reg  <= 32'h0000_0000;
      lhsec_reg <= 32'h0000_0000;
      life_reg  <= 32'h0000_0000;
    end else if (lsec_reg == `DIC_SEC_CYCLES - 32'h0000_0001) begin
      lsec_reg <= 32'h0000_0000;
      if (lhsec_reg == `DIC_HOUR_SECONDS - 32'h0000_0001) begin
        lhsec_reg <= 32'h0000_0000;
        life_reg  <= life_reg + 32'h0000_0001;
      end else begin
        lhsec_reg <= lhsec_reg + 32'h0000_0001;
      end
    end else begin
      lsec_reg <= lsec_reg + 32'h0000_0001;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_nc_stop_falls: assert property (@(posedge clk_i) disable iff (rst_i)
    (src == DIC_SRC_TERMINAL && macro == 3'h2 && fall.di1)
    |=> !run_reg) else $error("nc stop edge did not stop");
  a_latched_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    (src == DIC_SRC_TERMINAL && macro == 3'h0 && !t_reg.di1)
    |=> !run_reg) else $error("open stop still running");
  a_start_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    (src == DIC_SRC_TERMINAL && macro == 3'h2 && t_reg.di1 && rise.di2
     && !fall.di4) |=> run_reg && !rev_reg)
    else $error("start forward ignored");
  a_start_rev: assert property (@(posedge clk_i) disable iff (rst_i)
    (src == DIC_SRC_TERMINAL && macro == 3'h2 && t_reg.di1 && rise.di3
     && !rise.di2 && !fall.di4) |=> run_reg && rev_reg)
    else $error("start reverse ignored");
  a_bus_needs_en: assert property (@(posedge clk_i) disable iff (rst_i)
    (src == DIC_SRC_FIELDBUS && !enable) |=> !run_reg)
    else $error("fieldbus run without enable");
  a_fast_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    (src == DIC_SRC_TERMINAL && macro == 3'h2 && fall.di4)
    |=> fast_reg && !run_reg) else $error("fast stop missed");
  a_fire_count: assert property (@(posedge clk_i) disable iff (rst_i)
    rise.fire_mode |=> fcount_reg == $past(fcount_reg) + 32'h0000_0001)
    else $error("fire activation not counted");
  a_edge_once: assert property (@(posedge clk_i) disable iff (rst_i)
    rise.di2 |=> !rise.di2) else $error("edge repeated");
  a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held too long");
  c_latched_run: cover property (@(posedge clk_i) disable iff (rst_i)
    macro == 3'h0 && run_reg);
  c_pair_start: cover property (@(posedge clk_i) disable iff (rst_i)
    macro == 3'h3 && set_run);
  c_keypad_arm: cover property (@(posedge clk_i) disable iff (rst_i)
    armed_reg ##1 run_reg);
  c_bus_start: cover property (@(posedge clk_i) disable iff (rst_i)
    bus_run ##1 run_reg);
endmodule
`default_nettype wire

// ===== verilog/dic_consts.svh
`ifndef DIC_CONSTS_SVH
`define DIC_CONSTS_SVH
// ************************************************************
// register byte offsets
// ************************************************************
`define DIC_ADR_CTRL     8'h00
`define DIC_ADR_STATUS   8'h04
`define DIC_ADR_FCOUNT   8'h08
`define DIC_ADR_FTIME    8'h0C
`define DIC_ADR_LIFE     8'h10
// ************************************************************
// control register fields
// ************************************************************
`define DIC_CTL_MACRO_LSB 0
`define DIC_CTL_MACRO_MSB 2
`define DIC_CTL_SRC_LSB   4
`define DIC_CTL_SRC_MSB   5
`define DIC_CTL_KPD_AUTO  8
`define DIC_CTL_PWR_AUTO  9
`define DIC_CTL_BUS_RUN   12
`define DIC_CTL_BUS_REV   13
`define DIC_CTL_KPD_START 14
`define DIC_CTL_KPD_STOP  15
`define DIC_CTL_RESET     32'h0000_0000
// ************************************************************
// timing: seconds and hours from a 250 MHz clock
// ************************************************************
`define DIC_CLK_HZ        250000000
`define DIC_SEC_CYCLES    32'(`DIC_CLK_HZ)
`define DIC_HOUR_SECONDS  32'(3600)
`endif

// ===== verilog/dic_pkg.sv
`default_nettype none
package dic_pkg;
  // control source of the drive
  typedef enum logic [1:0] {
    DIC_SRC_TERMINAL,
    DIC_SRC_KEYPAD,
    DIC_SRC_FIELDBUS
  } dic_src_e;
  // raw terminal inputs
  typedef struct packed {
    logic fire_mode;
    logic di4;
    logic di3;
    logic di2;
    logic di1;
  } dic_term_s;
  // decoded drive command
  typedef struct packed {
    logic run;
    logic reverse_select;
    logic fast_stop;
  } dic_cmd_s;
endpackage
`default_nettype wire

// ===== verif/dic_contact_model.sv
`default_nettype none
module dic_contact_model (
  // clock
  input  wire logic               clk_i,
  // contact states the operator asks for, closed = 1
  input  wire dic_pkg::dic_term_s press_i,
  // levels seen at the terminals
  output var  dic_pkg::dic_term_s term_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dic_pkg::*;
  // contacts move one edge after the request, never mid-cycle
  always_ff @(posedge clk_i) begin
    term_o <= press_i;
  end
endmodule
`default_nettype wire

// ===== verif/drive_input_command_decoder_tb_top.sv
`include "dic_consts.svh"
`default_nettype none
module drive_input_command_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dic_pkg::*;
  // ********
  // signals
  // ********
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat;
  logic [31:0] dat_o;
  logic        ack_o;
  dic_term_s   press;
  dic_term_s   term;
  dic_cmd_s    cmd;
  int          miscompares;
  int          samples_checked;

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  dic_decoder i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .term_i(term), .cmd_o(cmd)
  );

  dic_contact_model i_contacts (
    .clk_i(clk_i), .press_i(press), .term_o(term)
  );

  // ********
  // tasks
  // ********
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // wait for ack without assuming its latency; the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd(input string what, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, 4'hF, q);
    check(what, q, e);
  endtask

  // covers the sample stage, the edge compare and the command register
  task automatic hit(input logic [4:0] v);
    @(posedge clk_i);
    press <= v;
    repeat (5) @(posedge clk_i);
  endtask

  task automatic cmdc(input logic [2:0] e);
    check("cmd", {29'h0, cmd}, {29'h0, e});
  endtask

  task automatic runc(input logic e);
    check("run", {31'h0, cmd.run}, {31'h0, e});
  endtask

  task automatic fastc;
    check("fast", {30'h0, cmd.run, cmd.fast_stop}, 32'h0000_0001);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    summarize();
  end

  // ********
  // tests
  // ********
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0000_0000;
    press = '0;
    miscompares = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl", `DIC_ADR_CTRL, `DIC_CTL_RESET);
    rd("status", `DIC_ADR_STATUS, 32'h0000_0000);
    rd("fcount", `DIC_ADR_FCOUNT, 32'h0000_0000);
    rd("ftime", `DIC_ADR_FTIME, 32'h0000_0000);
    rd("life", `DIC_ADR_LIFE, 32'h0000_0000);
    rd("unmapped", 8'h20, 32'h0000_0000);
    begin : sel_lane
      logic [31:0] q;
      wb(1'b1, `DIC_ADR_CTRL, 32'hFFFF_FF13, 4'h1, q);
    end
    rd("ctrl_lane", `DIC_ADR_CTRL, 32'h0000_0013);
    // latched stop, run, direction
    wr(`DIC_ADR_CTRL, 32'h0000_0000);
    hit(5'h01);
    cmdc(3'h0);
    hit(5'h03);
    cmdc(3'h4);
    hit(5'h07);
    cmdc(3'h6);
    rd("status_run", `DIC_ADR_STATUS, 32'h0000_0003);
    hit(5'h06);
    runc(1'b0);
    hit(5'h00);
    // latched run forward and run reverse
    wr(`DIC_ADR_CTRL, 32'h0000_0001);
    hit(5'h03);
    cmdc(3'h4);
    hit(5'h01);
    cmdc(3'h0);
    hit(5'h05);
    cmdc(3'h6);
    hit(5'h01);
    // direction holds after the stop
    cmdc(3'h2);
    hit(5'h00);
    // momentary starts; an open stop contact blocks the start
    wr(`DIC_ADR_CTRL, 32'h0000_0002);
    hit(5'h08);
    hit(5'h0A);
    hit(5'h08);
    runc(1'b0);
    hit(5'h09);
    hit(5'h0B);
    hit(5'h09);
    cmdc(3'h4);
    hit(5'h08);
    hit(5'h09);
    runc(1'b0);
    hit(5'h0D);
    hit(5'h09);
    cmdc(3'h6);
    hit(5'h01);
    fastc();
    hit(5'h00);
    // paired start and paired fast stop
    wr(`DIC_ADR_CTRL, 32'h0000_0003);
    hit(5'h01);
    hit(5'h03);
    hit(5'h01);
    runc(1'b0);
    hit(5'h07);
    hit(5'h01);
    runc(1'b1);
    hit(5'h0B);
    hit(5'h01);
    fastc();
    hit(5'h00);
    // simple run and reverse routing
    wr(`DIC_ADR_CTRL, 32'h0000_0005);
    hit(5'h03);
    cmdc(3'h6);
    hit(5'h00);
    // keypad: enable starts at once, or only arms
    wr(`DIC_ADR_CTRL, 32'h0000_0110);
    hit(5'h01);
    runc(1'b1);
    hit(5'h00);
    wr(`DIC_ADR_CTRL, 32'h0000_0010);
    hit(5'h01);
    runc(1'b0);
    rd("armed", `DIC_ADR_STATUS, 32'h0000_0008);
    wr(`DIC_ADR_CTRL, 32'h0000_4010);
    hit(5'h01);
    runc(1'b1);
    wr(`DIC_ADR_CTRL, 32'h0000_8010);
    hit(5'h01);
    runc(1'b0);
    hit(5'h00);
    // fieldbus start needs the enable first
    wr(`DIC_ADR_CTRL, 32'h0000_1020);
    hit(5'h00);
    runc(1'b0);
    // enable arriving after the start bit must not start the drive
    hit(5'h01);
    runc(1'b0);
    wr(`DIC_ADR_CTRL, 32'h0000_0020);
    hit(5'h01);
    wr(`DIC_ADR_CTRL, 32'h0000_3020);
    hit(5'h01);
    cmdc(3'h6);
    wr(`DIC_ADR_CTRL, 32'h0000_0000);
    hit(5'h00);
    // fire mode log and read-only counters
    hit(5'h10);
    hit(5'h00);
    hit(5'h10);
    hit(5'h00);
    rd("fcount", `DIC_ADR_FCOUNT, 32'h0000_0002);
    wr(`DIC_ADR_FTIME, 32'hFFFF_FFFF);
    rd("ftime", `DIC_ADR_FTIME, 32'h0000_0000);
    wr(`DIC_ADR_LIFE, 32'hFFFF_FFFF);
    rd("life", `DIC_ADR_LIFE, 32'h0000_0000);
    // run level present through reset waits until auto start is set
    @(posedge clk_i);
    rst_i <= 1'b1;
    press <= 5'h03;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    runc(1'b0);
    wr(`DIC_ADR_CTRL, 32'h0000_0200);
    hit(5'h03);
    runc(1'b1);
    summarize();
  end
endmodule
`default_nettype wire
